// [ovl_status_irq_regs.sv]
// status, channel control and interrupt registers of the overlay layer
`timescale 1ns/100ps

// How it works
// - status bit 0 reads one while the fetch channel is enabled.
// - status bit 1 holds one from attribute update request until frame start applies it.
// - status bit 2 holds one while a queued head pointer is still pending.
// - enable-set write: ones enable sources, zeros change nothing.
// - enable-clear write: ones disable sources, zeros change nothing.
// - mask view reads one per currently enabled source.
// - primary channel sources sit at bits 2 to 6.
// - U or UV channel sources sit at bits 10 to 14, same order.
// - V channel sources sit at bits 18 to 22, same order.
// - transfer end event sets that channel's transfer-end flag.
// - descriptor fetched sets that channel's descriptor-loaded flag.
// - head descriptor loaded sets that channel's head-loaded flag.
// - end of descriptor list sets that channel's end-of-list flag.
// - pixel fetch overflow sets that channel's overflow flag.
// - reading the flag register clears the flags it returned.
// - head queue request and pending bit clear once pointer is appended.
// - writing one schedules attributes for next frame start; zero does nothing.
// - stop request lets the frame finish, channel turns off at frame end.

module ovl_status_irq_regs
	import ovl_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// fetch channel events, one bit per channel (0 primary, 1 u/uv, 2 v)
	input wire logic [2:0] XFER_END,
	input wire logic [2:0] DESC_LOADED,
	input wire logic [2:0] HEAD_LOADED,
	input wire logic [2:0] LIST_END,
	input wire logic [2:0] FETCH_OVERFLOW,
	// frame timing and queue completion from the layer engine
	input wire logic FRAME_START,
	input wire logic FRAME_END,
	input wire logic HEAD_APPENDED,
	// control towards the layer engine
	output logic CHANNEL_ENABLED,
	output logic ATTR_REFRESH_PENDING,
	output logic ATTR_APPLY,
	output logic HEAD_QUEUE_REQUEST,
	// interrupt request
	output logic IRQ
);

	// ==========================================================
	// bus decode
	wire access_w = PSEL & PENABLE;
	// first access cycle: data is prepared, answer comes next cycle
	wire prep_w = access_w & ~PREADY;
	// completing edge: pready sampled high
	wire done_w = access_w & PREADY;
	wire wr_done_w = done_w & PWRITE;
	wire rd_done_w = done_w & ~PWRITE;

	wire hit_start_w = (PADDR == OVL_ADDR_CHAN_ENABLE);
	wire hit_stop_w = (PADDR == OVL_ADDR_CHAN_DISABLE);
	wire hit_stat_w = (PADDR == OVL_ADDR_CHANNEL_STATUS);
	wire hit_ier_w = (PADDR == OVL_ADDR_IRQ_ENABLE_SET);
	wire hit_idr_w = (PADDR == OVL_ADDR_IRQ_ENABLE_CLEAR);
	wire hit_imr_w = (PADDR == OVL_ADDR_IRQ_MASK_VIEW);
	wire hit_flag_w = (PADDR == OVL_ADDR_IRQ_FLAGS);
	wire mapped_w = hit_start_w | hit_stop_w | hit_stat_w | hit_ier_w
		| hit_idr_w | hit_imr_w | hit_flag_w;

	// ==========================================================
	// state registers
	logic enabled_q;
	logic enabled_d;
	logic stop_pend_q;
	logic stop_pend_d;
	logic attr_pend_q;
	logic attr_pend_d;
	logic attr_apply_q;
	logic head_pend_q;
	logic head_pend_d;
	logic [31:0] mask_q;
	logic [31:0] mask_d;
	logic [31:0] flags_q;
	logic [31:0] flags_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	// ==========================================================
	// channel control writes
	wire wr_start_w = wr_done_w & hit_start_w;
	wire wr_stop_w = wr_done_w & hit_stop_w;
	wire set_en_w = wr_start_w & PWDATA[OVL_BIT_CHAN_EN];
	wire set_attr_w = wr_start_w & PWDATA[OVL_BIT_ATTR_REFRESH];
	wire set_head_w = wr_start_w & PWDATA[OVL_BIT_HEAD_QUEUE];
	wire set_stop_w = wr_stop_w & PWDATA[OVL_BIT_LAYER_STOP];
	wire abort_w = wr_stop_w & PWDATA[OVL_BIT_LAYER_ABORT];

	// stop takes effect only at the end of the running frame
	wire stop_now_w = (stop_pend_q | set_stop_w) & FRAME_END;

	// an enable write in the same cycle as a stop wins for the next frame
	assign enabled_d = set_en_w ? 1'h1
		: (abort_w | stop_now_w) ? 1'h0
		: enabled_q;
	assign stop_pend_d = set_en_w | abort_w | stop_now_w ? 1'h0
		: (stop_pend_q | set_stop_w);

	// request wins over the frame start that would clear it
	wire attr_fire_w = attr_pend_q & FRAME_START;
	assign attr_pend_d = set_attr_w | (attr_pend_q & ~FRAME_START);

	// pointer appended clears the request, a new request wins
	assign head_pend_d = set_head_w | (head_pend_q & ~HEAD_APPENDED);

	// ==========================================================
	// interrupt sources
	logic [31:0] ev_chan_w [OVL_NUM_CHAN];

	// one event group per fetch channel (0 primary, 1 u/uv, 2 v)
	genvar ch;
	generate
		for (ch = 0; ch < OVL_NUM_CHAN; ch++)
		begin : g_chan
			ovl_chan_events #(
				.BASE(OVL_CHAN_FIRST_BIT + ch * OVL_CHAN_BIT_STEP)
			) u_events (
				.xfer_end(XFER_END[ch]),
				.desc_loaded(DESC_LOADED[ch]),
				.head_loaded(HEAD_LOADED[ch]),
				.list_end(LIST_END[ch]),
				.fetch_overflow(FETCH_OVERFLOW[ch]),
				.set_word(ev_chan_w[ch])
			);
		end
	endgenerate

	// unused positions carry no event, each group sets only its own bits
	wire [31:0] ev_set_w = ev_chan_w[0] | ev_chan_w[1] | ev_chan_w[2];

	// ==========================================================
	// mask and flag updates
	wire [31:0] ier_bits_w = (wr_done_w & hit_ier_w) ? PWDATA : 32'h00000000;
	wire [31:0] idr_bits_w = (wr_done_w & hit_idr_w) ? PWDATA : 32'h00000000;

	assign mask_d = ((mask_q | ier_bits_w) & ~idr_bits_w) & OVL_IRQ_VALID;

	// only the bits actually returned are cleared; a set in the same cycle wins
	wire [31:0] flag_clr_w = (rd_done_w & hit_flag_w) ? prdata_q : 32'h00000000;
	assign flags_d = ((flags_q & ~flag_clr_w) | ev_set_w) & OVL_IRQ_VALID;

	wire irq_d = |(flags_d & mask_d);

	// ==========================================================
	// read data
	wire [31:0] st_en_w = 32'(enabled_q) << OVL_BIT_CHAN_EN;
	wire [31:0] st_attr_w = 32'(attr_pend_q) << OVL_BIT_ATTR_REFRESH;
	wire [31:0] st_head_w = 32'(head_pend_q) << OVL_BIT_HEAD_QUEUE;
	wire [31:0] status_w = st_en_w | st_attr_w | st_head_w;

	assign prdata_d = ~prep_w | PWRITE ? 32'h00000000
		: hit_stat_w ? status_w
		: hit_imr_w ? mask_q
		: hit_flag_w ? flags_q
		: 32'h00000000;

	// ==========================================================
	// registers
	always_ff @(posedge CLK)
	begin
		if (RST)
			enabled_q <= 1'h0;
		else
			enabled_q <= enabled_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			stop_pend_q <= 1'h0;
		else
			stop_pend_q <= stop_pend_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			attr_pend_q <= 1'h0;
		else
			attr_pend_q <= attr_pend_d;
	end

	// one-cycle pulse to the layer engine
	always_ff @(posedge CLK)
	begin
		if (RST)
			attr_apply_q <= 1'h0;
		else
			attr_apply_q <= attr_fire_w;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			head_pend_q <= 1'h0;
		else
			head_pend_q <= head_pend_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			mask_q <= OVL_RESET_WORD;
		else
			mask_q <= mask_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			flags_q <= OVL_RESET_WORD;
		else
			flags_q <= flags_d;
	end

	// follows flags and mask in the same edge
	always_ff @(posedge CLK)
	begin
		if (RST)
			irq_q <= 1'h0;
		else
			irq_q <= irq_d;
	end

	// ==========================================================
	// apb answer: one wait state on every access
	always_ff @(posedge CLK)
	begin
		if (RST)
			prdata_q <= OVL_RESET_WORD;
		else
			prdata_q <= prdata_d;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			pready_q <= 1'h0;
		else
			pready_q <= prep_w;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			pslverr_q <= 1'h0;
		else
			pslverr_q <= prep_w & ~mapped_w;
	end

	// ==========================================================
	// outputs
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign CHANNEL_ENABLED = enabled_q;
	assign ATTR_REFRESH_PENDING = attr_pend_q;
	assign ATTR_APPLY = attr_apply_q;
	assign HEAD_QUEUE_REQUEST = head_pend_q;
	assign IRQ = irq_q;

endmodule

// ==========================================================
// event group of one fetch channel
module ovl_chan_events
	import ovl_pkg::*;
#(
	parameter int BASE = OVL_CHAN_FIRST_BIT
)
(
	// events of the channel
	input wire logic xfer_end,
	input wire logic desc_loaded,
	input wire logic head_loaded,
	input wire logic list_end,
	input wire logic fetch_overflow,
	// flag bits set this cycle
	output logic [31:0] set_word
);

	wire [31:0] xfer_w = 32'(xfer_end) << (BASE + OVL_EV_XFER_END);
	wire [31:0] desc_w = 32'(desc_loaded) << (BASE + OVL_EV_DESC_LOADED);
	wire [31:0] head_w = 32'(head_loaded) << (BASE + OVL_EV_HEAD_LOADED);
	wire [31:0] list_w = 32'(list_end) << (BASE + OVL_EV_LIST_END);
	wire [31:0] ovf_w = 32'(fetch_overflow) << (BASE + OVL_EV_OVERFLOW);

	assign set_word = xfer_w | desc_w | head_w | list_w | ovf_w;

endmodule

// [ovl_pkg.sv]
// constants for the overlay layer status and interrupt registers
package ovl_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [31:0] OVL_ADDR_CHAN_ENABLE = 32'hf8038280;
	localparam logic [31:0] OVL_ADDR_CHAN_DISABLE = 32'hf8038284;
	localparam logic [31:0] OVL_ADDR_CHANNEL_STATUS = 32'hf8038288;
	localparam logic [31:0] OVL_ADDR_IRQ_ENABLE_SET = 32'hf803828c;
	localparam logic [31:0] OVL_ADDR_IRQ_ENABLE_CLEAR = 32'hf8038290;
	localparam logic [31:0] OVL_ADDR_IRQ_MASK_VIEW = 32'hf8038294;
	localparam logic [31:0] OVL_ADDR_IRQ_FLAGS = 32'hf8038298;

	// ==========================================================
	// reset values
	localparam logic [31:0] OVL_RESET_WORD = 32'h00000000;

	// ==========================================================
	// channel control and status fields
	localparam int OVL_BIT_CHAN_EN = 0;
	localparam int OVL_BIT_ATTR_REFRESH = 1;
	localparam int OVL_BIT_HEAD_QUEUE = 2;
	localparam int OVL_BIT_LAYER_STOP = 0;
	localparam int OVL_BIT_LAYER_ABORT = 8;

	// ==========================================================
	// interrupt source layout: five events per fetch channel
	localparam int OVL_NUM_CHAN = 3;
	localparam int OVL_NUM_EVENT = 5;
	localparam int OVL_EV_XFER_END = 0;
	localparam int OVL_EV_DESC_LOADED = 1;
	localparam int OVL_EV_HEAD_LOADED = 2;
	localparam int OVL_EV_LIST_END = 3;
	localparam int OVL_EV_OVERFLOW = 4;
	localparam int OVL_CHAN_FIRST_BIT = 2;
	localparam int OVL_CHAN_BIT_STEP = 8;
	localparam logic [31:0] OVL_IRQ_VALID = 32'h007c7c7c;

endpackage

// [ovl_status_irq_regs_chk.sv]
// assertions for the overlay status and interrupt registers
`timescale 1ns/100ps
module ovl_status_irq_regs_chk
	import ovl_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PRDATA,
	// frame events and control
	input wire logic FRAME_START,
	input wire logic FRAME_END,
	input wire logic HEAD_APPENDED,
	input wire logic CHANNEL_ENABLED,
	input wire logic ATTR_REFRESH_PENDING,
	input wire logic ATTR_APPLY,
	input wire logic HEAD_QUEUE_REQUEST
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire wr = PSEL && PENABLE && PWRITE && PREADY;
	wire fs_pend = FRAME_START && ATTR_REFRESH_PENDING;
	wire stop_cause = FRAME_END || wr;
	wire hq_done = HEAD_QUEUE_REQUEST && HEAD_APPENDED && !wr;
	wire mapped = PADDR >= OVL_ADDR_CHAN_ENABLE && PADDR <= OVL_ADDR_IRQ_FLAGS
		&& PADDR[1:0] == 2'h0;
	sequence s_apply;
		fs_pend ##1 ATTR_APPLY;
	endsequence
	property p_apply;
		fs_pend |-> s_apply;
	endproperty
	property p_pend_clr;
		fs_pend && !wr |=> !ATTR_REFRESH_PENDING;
	endproperty
	property p_hq_set;
		$rose(HEAD_QUEUE_REQUEST) |-> $past(wr);
	endproperty
	property p_hq_clr;
		hq_done |=> !HEAD_QUEUE_REQUEST;
	endproperty
	property p_en_set;
		$rose(CHANNEL_ENABLED) |-> $past(wr);
	endproperty
	property p_stop;
		$fell(CHANNEL_ENABLED) |-> $past(stop_cause);
	endproperty
	property p_unused;
		(PRDATA & ~(OVL_IRQ_VALID | 32'h7)) == 32'h0;
	endproperty
	property p_err;
		PREADY |-> PSLVERR == !mapped;
	endproperty
	a_apply: assert property (p_apply) else $error("no apply pulse");
	a_pend_clr: assert property (p_pend_clr) else $error("pending kept");
	a_hq_set: assert property (p_hq_set) else $error("queue set alone");
	a_hq_clr: assert property (p_hq_clr) else $error("queue kept");
	a_en_set: assert property (p_en_set) else $error("enable alone");
	a_stop: assert property (p_stop) else $error("early stop");
	a_unused: assert property (p_unused) else $error("unused bit set");
	a_err: assert property (p_err) else $error("bad error flag");
endmodule

bind ovl_status_irq_regs ovl_status_irq_regs_chk u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR),
	.PRDATA(PRDATA), .FRAME_START(FRAME_START), .FRAME_END(FRAME_END),
	.HEAD_APPENDED(HEAD_APPENDED), .CHANNEL_ENABLED(CHANNEL_ENABLED),
	.ATTR_REFRESH_PENDING(ATTR_REFRESH_PENDING), .ATTR_APPLY(ATTR_APPLY),
	.HEAD_QUEUE_REQUEST(HEAD_QUEUE_REQUEST));

// [ovl_status_irq_regs_tb.sv]
// self-checking bench for the overlay status and interrupt registers
`timescale 1ns/100ps
module ovl_status_irq_regs_tb;
	import ovl_pkg::*;
	localparam logic [31:0] MASK_EXP = OVL_IRQ_VALID & ~32'h00000404;
	logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err, IRQ;
	logic FRAME_START = 0, FRAME_END = 0, HEAD_APPENDED = 0, ATTR_APPLY;
	logic CHANNEL_ENABLED, ATTR_REFRESH_PENDING, HEAD_QUEUE_REQUEST;
	logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, rd, exp_flag;
	logic [14:0] ev = 0;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	always #5 CLK = ~CLK;
	ovl_status_irq_regs uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .XFER_END(ev[2:0]), .DESC_LOADED(ev[5:3]), .HEAD_LOADED(ev[8:6]),
		.LIST_END(ev[11:9]), .FETCH_OVERFLOW(ev[14:12]), .FRAME_START(FRAME_START),
		.FRAME_END(FRAME_END), .HEAD_APPENDED(HEAD_APPENDED), .IRQ(IRQ),
		.CHANNEL_ENABLED(CHANNEL_ENABLED), .ATTR_REFRESH_PENDING(ATTR_REFRESH_PENDING),
		.ATTR_APPLY(ATTR_APPLY), .HEAD_QUEUE_REQUEST(HEAD_QUEUE_REQUEST));
	task check(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		@(posedge CLK);
		while (PREADY !== 1'h1)
			@(posedge CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CLK);
	endtask
	task rdchk(input logic [31:0] a, input logic [31:0] want);
		apb(1'h0, a, 32'h0);
		check(rd, want);
	endtask
	// frame start, frame end, head appended, then the event bits
	task pulse(input logic [17:0] f);
		{FRAME_START, FRAME_END, HEAD_APPENDED, ev} <= f;
		@(posedge CLK);
		{FRAME_START, FRAME_END, HEAD_APPENDED, ev} <= 18'h0;
		@(posedge CLK);
	endtask
	task summarize;
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		repeat (6) @(posedge CLK);
		RST <= 1'h0;
		@(posedge CLK);
		for (int a = 0; a < 7; a++)
			rdchk(OVL_ADDR_CHAN_ENABLE + 32'(4 * a), OVL_RESET_WORD);
		rdchk(OVL_ADDR_IRQ_FLAGS + 32'h4, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("done: reset and decode");
		apb(1'h1, OVL_ADDR_IRQ_ENABLE_SET, 32'hffffffff);
		rdchk(OVL_ADDR_IRQ_MASK_VIEW, OVL_IRQ_VALID);
		apb(1'h1, OVL_ADDR_IRQ_ENABLE_CLEAR, 32'h00000404);
		apb(1'h1, OVL_ADDR_IRQ_ENABLE_SET, 32'h0);
		apb(1'h1, OVL_ADDR_IRQ_ENABLE_CLEAR, 32'h0);
		apb(1'h1, OVL_ADDR_IRQ_MASK_VIEW, 32'h0);
		rdchk(OVL_ADDR_IRQ_MASK_VIEW, MASK_EXP);
		for (int e = 0; e < OVL_NUM_EVENT; e++)
			for (int c = 0; c < OVL_NUM_CHAN; c++)
			begin
				exp_flag = 32'h1 << (OVL_CHAN_FIRST_BIT + OVL_CHAN_BIT_STEP * c + e);
				pulse(18'h1 << (3 * e + c));
				check({31'h0, IRQ}, {31'h0, (exp_flag & MASK_EXP) != 0});
				rdchk(OVL_ADDR_IRQ_FLAGS, exp_flag);
				rdchk(OVL_ADDR_IRQ_FLAGS, 32'h0);
				check({31'h0, IRQ}, 32'h0);
			end
		$display("done: events and flags");
		apb(1'h1, OVL_ADDR_CHAN_ENABLE, 32'h0);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h0);
		apb(1'h1, OVL_ADDR_CHAN_ENABLE, 32'h7);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h7);
		check({HEAD_QUEUE_REQUEST, ATTR_REFRESH_PENDING, CHANNEL_ENABLED}, 32'h7);
		pulse(18'h20000);
		check({31'h0, ATTR_APPLY}, 32'h1);
		pulse(18'h08000);
		check({31'h0, ATTR_APPLY}, 32'h0);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h1);
		apb(1'h1, OVL_ADDR_CHAN_DISABLE, 32'h1);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h1);
		pulse(18'h10000);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h0);
		apb(1'h1, OVL_ADDR_CHAN_ENABLE, 32'h1);
		check({31'h0, CHANNEL_ENABLED}, 32'h1);
		apb(1'h1, OVL_ADDR_CHAN_DISABLE, 32'h1 << OVL_BIT_LAYER_ABORT);
		rdchk(OVL_ADDR_CHANNEL_STATUS, 32'h0);
		check({31'h0, err}, 32'h0);
		$display("done: channel status");
		summarize();
	end
endmodule
